// ---- ssmp_top.sv ----
// synchronous serial interface: mode decode, pin switching and shift engine
`include "ssmp_defs.svh"
`default_nettype none

module ssmp_top #(
  parameter int unsigned SLOW_HALF = `SSMP_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = `SSMP_FAST_HALF_CYC
) (
  input wire logic clk, // system clock, 10 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic serial_enable_bit, // enables the serial function
  input wire logic master_select_bit, // 1 selects master
  input wire logic handshake_pin_enable, // bit 3 used by the interface in slave modes
  input wire logic ready_output_select, // bit 3 is ready out, else select in
  input wire logic data_out_pin_enable, // bit 1 becomes serial data out
  input wire ssmp_pkg::ssmp_cks_t clock_source_select, // master clock source
  input wire logic clk_polarity_neg, // 1 inverts the shift clock
  input wire logic clk_phase_alt, // 1 samples on the trailing edge
  input wire logic lsb_first, // bit order of the transfer
  input wire logic [3:0] port_dir, // port 3 direction, 1 is output
  input wire logic [3:0] port_data, // port 3 output data
  input wire logic [3:0] port_pulldown, // port 3 pull-down control
  input wire logic timer_tick, // timer underflow pulse
  input wire logic [7:0] tx_data, // parallel data to send
  input wire logic transfer_trigger_bit, // pulse, starts a transfer
  input wire logic data_hi_access, // pulse, upper data nibble accessed
  input wire logic done_clear, // pulse, clears the done flag
  input wire logic [3:0] port3_in, // pin levels, asynchronous
  output logic [3:0] port3_out, // pin output levels
  output logic [3:0] port3_oe, // pin output enables, 1 drives
  output logic [3:0] port3_pd, // pin pull-down enables
  output logic [3:0] port_in_value, // synchronised pin levels
  output logic [7:0] rx_data, // shift register contents
  output logic busy, // transfer in progress
  output logic transfer_done_flag, // sticky completion flag
  output logic irq_request, // one-cycle completion pulse
  output ssmp_pkg::ssmp_mode_t mode // decoded operating mode
);
  import ssmp_pkg::*;

  // ==========================================================================
  // state
  ssmp_state_t state_q, state_d;
  logic [7:0] sr_q, sr_d;
  logic [`SSMP_BIT_CNT_W-1:0] bit_q, bit_d;
  logic [`SSMP_HALF_CNT_W-1:0] half_q, half_d;
  logic mclk_q, mclk_d;
  logic lprev_q, lprev_d;
  logic serial_data_out_pin_q, serial_data_out_pin_d;
  logic pend_q, pend_d;
  logic slave_ready_pin_q, slave_ready_pin_d;
  logic flag_q, flag_d;
  logic irq_q, irq_d;
  logic [3:0] out_q, out_d;
  logic [3:0] oe_q, oe_d;
  logic [3:0] pd_q, pd_d;

  // ==========================================================================
  // helpers
  logic [3:0] pin_s;
  logic half_tick;
  logic run_master;
  logic slave_lvl;
  logic sel_ok;
  logic rise;
  logic fall;
  logic sample;
  logic change;
  logic done_evt;

  // bit presented on the data-out pin for a given register value
  function automatic logic out_bit(input logic [7:0] sr, input logic lsb);
    out_bit = lsb ? sr[0] : sr[7];
  endfunction : out_bit

  // one shift step, taking the data-in bit at the far end
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction : shift_in

  // ==========================================================================
  // pins come from outside the clock domain
  ssmp_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(port3_in),
    .q(pin_s)
  );

  // ==========================================================================
  // mode decode; the prohibited all-ones setting falls back to port use
  always_comb begin
    if (!serial_enable_bit) begin
      mode = SSMP_MODE_OFF;
    end else if (master_select_bit && handshake_pin_enable && ready_output_select) begin
      mode = SSMP_MODE_OFF;
    end else if (master_select_bit) begin
      mode = SSMP_MODE_MASTER;
    end else if (handshake_pin_enable && !ready_output_select) begin
      mode = SSMP_MODE_SPI;
    end else begin
      mode = SSMP_MODE_SLAVE;
    end
  end

  // ==========================================================================
  // master clock source: runs only while a master transfer is active
  assign run_master = (state_q == SSMP_ST_RUN) && (mode == SSMP_MODE_MASTER);

  ssmp_clkgen #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF)
  ) u_clkgen (
    .clk(clk),
    .rst_n(rst_n),
    .run(run_master),
    .cks(clock_source_select),
    .timer_tick(timer_tick),
    .half_tick(half_tick)
  );

  // ==========================================================================
  // clock edges in the polarity-normalised sense; slave edges come from the
  // synchronised pin, so the external clock must stay well below clk / 4
  assign slave_lvl = pin_s[`SSMP_PIN_SCLK] ^ clk_polarity_neg;
  // in SPI slave mode the external select must be low before edges count
  assign sel_ok = (mode == SSMP_MODE_SLAVE) ||
                  ((mode == SSMP_MODE_SPI) && !pin_s[`SSMP_PIN_RDY]);

  always_comb begin
    rise = 1'b0;
    fall = 1'b0;
    if (state_q == SSMP_ST_RUN) begin
      if (mode == SSMP_MODE_MASTER) begin
        rise = half_tick && !mclk_q;
        fall = half_tick && mclk_q;
      end else if (sel_ok) begin
        rise = slave_lvl && !lprev_q;
        fall = !slave_lvl && lprev_q;
      end
    end
  end

  assign sample = clk_phase_alt ? fall : rise;
  assign change = rise;

  // ==========================================================================
  // transfer engine: load, shift eight bits, report completion
  always_comb begin
    state_d = state_q;
    sr_d = sr_q;
    bit_d = bit_q;
    half_d = half_q;
    mclk_d = mclk_q;
    lprev_d = slave_lvl;
    serial_data_out_pin_d = serial_data_out_pin_q;
    pend_d = pend_q;
    slave_ready_pin_d = slave_ready_pin_q;
    done_evt = 1'b0;
    case (state_q)
      SSMP_ST_IDLE: begin
        mclk_d = 1'b0;
        half_d = '0;
        // a trigger is taken only with the interface enabled
        if (transfer_trigger_bit && mode != SSMP_MODE_OFF) begin
          state_d = SSMP_ST_RUN;
          sr_d = tx_data;
          bit_d = '0;
          pend_d = 1'b0;
          serial_data_out_pin_d = out_bit(tx_data, lsb_first);
          // ready raised by hardware at once, for slave mode only
          slave_ready_pin_d = (mode == SSMP_MODE_SLAVE);
        end
      end
      SSMP_ST_RUN: begin
        // master clock toggles on each half period
        if (mode == SSMP_MODE_MASTER && half_tick) begin
          mclk_d = !mclk_q;
          half_d = half_q + `SSMP_HALF_CNT_W'(1);
        end
        if (sample) begin
          sr_d = shift_in(sr_q, pin_s[`SSMP_PIN_SIN], lsb_first);
          bit_d = bit_q + `SSMP_BIT_CNT_W'(1);
          pend_d = 1'b1;
          if (bit_q == `SSMP_BIT_CNT_W'(`SSMP_XFER_BITS - 1)) begin
            done_evt = 1'b1;
          end
        end
        // output moves to the next bit after a sample has happened; in the
        // default phase the sample and the change share one edge
        if (change && (pend_q || sample)) begin
          serial_data_out_pin_d = out_bit(sr_d, lsb_first);
          pend_d = 1'b0;
        end
        // the first active clock level ends the ready indication
        if (rise) begin
          slave_ready_pin_d = 1'b0;
        end
        // slave ends at the eighth sample, master after the last half period
        if (mode != SSMP_MODE_MASTER && done_evt) begin
          state_d = SSMP_ST_IDLE;
        end
        if (mode == SSMP_MODE_MASTER && half_tick &&
            half_q == `SSMP_HALF_CNT_W'(2 * `SSMP_XFER_BITS - 1)) begin
          state_d = SSMP_ST_IDLE;
        end
        // turning the interface off aborts the transfer
        if (mode == SSMP_MODE_OFF) begin
          state_d = SSMP_ST_IDLE;
          slave_ready_pin_d = 1'b0;
        end
      end
      default: begin
        state_d = SSMP_ST_IDLE;
      end
    endcase
    // software access to the upper nibble also drops ready
    if (data_hi_access) begin
      slave_ready_pin_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SSMP_ST_IDLE;
      sr_q <= `SSMP_SR_RESET;
      bit_q <= '0;
      half_q <= '0;
      mclk_q <= 1'b0;
      lprev_q <= 1'b0;
      serial_data_out_pin_q <= 1'b0;
      pend_q <= 1'b0;
      slave_ready_pin_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sr_q <= sr_d;
      bit_q <= bit_d;
      half_q <= half_d;
      mclk_q <= mclk_d;
      lprev_q <= lprev_d;
      serial_data_out_pin_q <= serial_data_out_pin_d;
      pend_q <= pend_d;
      slave_ready_pin_q <= slave_ready_pin_d;
    end
  end

  // ==========================================================================
  // completion flag: a set in the clearing cycle wins
  always_comb begin
    flag_d = done_evt || (flag_q && !done_clear);
    irq_d = done_evt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================================
  // pin switching; ports by default, serial functions override direction
  // and data, pull-downs stay under port control only on serial inputs
  always_comb begin
    oe_d = port_dir;
    out_d = port_data;
    pd_d = port_pulldown & ~port_dir;
    if (mode != SSMP_MODE_OFF) begin
      // shift clock pin
      if (mode == SSMP_MODE_MASTER) begin
        oe_d[`SSMP_PIN_SCLK] = 1'b1;
        out_d[`SSMP_PIN_SCLK] = mclk_q ^ clk_polarity_neg;
        pd_d[`SSMP_PIN_SCLK] = 1'b0;
      end else begin
        oe_d[`SSMP_PIN_SCLK] = 1'b0;
        out_d[`SSMP_PIN_SCLK] = 1'b0;
        pd_d[`SSMP_PIN_SCLK] = port_pulldown[`SSMP_PIN_SCLK];
      end
      // data-in pin
      oe_d[`SSMP_PIN_SIN] = 1'b0;
      out_d[`SSMP_PIN_SIN] = 1'b0;
      pd_d[`SSMP_PIN_SIN] = port_pulldown[`SSMP_PIN_SIN];
      // data-out pin only with its own enable
      if (data_out_pin_enable) begin
        oe_d[`SSMP_PIN_SERIAL_DATA_OUT_PIN] = 1'b1;
        out_d[`SSMP_PIN_SERIAL_DATA_OUT_PIN] = serial_data_out_pin_q;
        pd_d[`SSMP_PIN_SERIAL_DATA_OUT_PIN] = 1'b0;
      end
      // bit 3: ready out, select in, or left to the port
      if (mode == SSMP_MODE_SLAVE && handshake_pin_enable && ready_output_select) begin
        oe_d[`SSMP_PIN_RDY] = 1'b1;
        out_d[`SSMP_PIN_RDY] = slave_ready_pin_q ^ clk_polarity_neg;
        pd_d[`SSMP_PIN_RDY] = 1'b0;
      end else if (mode == SSMP_MODE_SPI) begin
        oe_d[`SSMP_PIN_RDY] = 1'b0;
        out_d[`SSMP_PIN_RDY] = 1'b0;
        pd_d[`SSMP_PIN_RDY] = port_pulldown[`SSMP_PIN_RDY];
      end
      // master mode keeps bit 3 as a port: ready and select are software's
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 4'h0;
      out_q <= 4'h0;
      pd_q <= 4'h0;
    end else begin
      oe_q <= oe_d;
      out_q <= out_d;
      pd_q <= pd_d;
    end
  end

  // ==========================================================================
  // outputs
  assign port3_out = out_q;
  assign port3_oe = oe_q;
  assign port3_pd = pd_q;
  assign port_in_value = pin_s;
  assign rx_data = sr_q;
  assign busy = (state_q == SSMP_ST_RUN);
  assign transfer_done_flag = flag_q;
  assign irq_request = irq_q;

endmodule : ssmp_top

`default_nettype wire

// ---- ssmp_defs.svh ----
// constants for the synchronous serial mode and pin configuration block
`ifndef SSMP_DEFS_SVH
`define SSMP_DEFS_SVH

// ==========================================================================
// clock and timing
`define SSMP_CLK_PERIOD_NS 100
// half period of the slowest base rate (32 kHz source), in ns
`define SSMP_SLOW_HALF_NS 15625
// half period of the fastest base rate (1 MHz ceiling), in ns
`define SSMP_FAST_HALF_NS 500
`define SSMP_SLOW_HALF_CYC (`SSMP_SLOW_HALF_NS / `SSMP_CLK_PERIOD_NS)
`define SSMP_FAST_HALF_CYC (`SSMP_FAST_HALF_NS / `SSMP_CLK_PERIOD_NS)

// ==========================================================================
// transfer geometry
`define SSMP_XFER_BITS 8
`define SSMP_BIT_CNT_W 4
`define SSMP_HALF_CNT_W 5
`define SSMP_DIV_CNT_W 12
`define SSMP_SR_RESET 8'h00

// ==========================================================================
// shared pin positions within port 3
`define SSMP_PIN_SCLK 0
`define SSMP_PIN_SERIAL_DATA_OUT_PIN 1
`define SSMP_PIN_SIN 2
`define SSMP_PIN_RDY 3

`endif

// ---- ssmp_pkg.sv ----
// types for the synchronous serial mode and pin configuration block
`default_nettype none

package ssmp_pkg;

  // ========================================================================
  // operating mode decoded from the control bits
  typedef enum logic [1:0] {
    SSMP_MODE_OFF    = 2'b00,
    SSMP_MODE_MASTER = 2'b01,
    SSMP_MODE_SLAVE  = 2'b10,
    SSMP_MODE_SPI    = 2'b11
  } ssmp_mode_t;

  // transfer clock source select
  typedef enum logic [2:0] {
    SSMP_CKS_OFF   = 3'b000,
    SSMP_CKS_SLOW1 = 3'b001,
    SSMP_CKS_SLOW2 = 3'b010,
    SSMP_CKS_SLOW4 = 3'b011,
    SSMP_CKS_TIMER = 3'b100,
    SSMP_CKS_FAST1 = 3'b101,
    SSMP_CKS_FAST2 = 3'b110,
    SSMP_CKS_FAST4 = 3'b111
  } ssmp_cks_t;

  // transfer engine state
  typedef enum logic [0:0] {
    SSMP_ST_IDLE = 1'b0,
    SSMP_ST_RUN  = 1'b1
  } ssmp_state_t;

endpackage : ssmp_pkg

`default_nettype wire

// ---- ssmp_sync.sv ----
// two-flop synchroniser for pin levels
`default_nettype none

module ssmp_sync #(
  parameter int unsigned W = 4
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  // ==========================================================================
  // next values: the first stage feeds only the second
  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end

endmodule : ssmp_sync

`default_nettype wire

// ---- ssmp_clkgen.sv ----
// master-mode half-period tick generator with seven selectable sources
`include "ssmp_defs.svh"
`default_nettype none

module ssmp_clkgen #(
  parameter int unsigned SLOW_HALF = `SSMP_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = `SSMP_FAST_HALF_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic run, // count only while a master transfer runs
  input wire ssmp_pkg::ssmp_cks_t cks, // source select
  input wire logic timer_tick, // timer underflow pulse, same domain
  output logic half_tick // one pulse per transfer-clock half period
);
  import ssmp_pkg::*;

  logic [`SSMP_DIV_CNT_W-1:0] cnt_q;
  logic [`SSMP_DIV_CNT_W-1:0] cnt_d;
  logic tick_d;
  logic [`SSMP_DIV_CNT_W-1:0] len;

  // half period in system clocks; the timer source uses each underflow
  // as one half period, which divides the underflow rate by two; the block
  // reads data-in through two flops, so halves under four clocks sample late
  function automatic logic [`SSMP_DIV_CNT_W-1:0] half_len(input ssmp_cks_t s);
    case (s)
      SSMP_CKS_SLOW1: half_len = `SSMP_DIV_CNT_W'(SLOW_HALF);
      SSMP_CKS_SLOW2: half_len = `SSMP_DIV_CNT_W'(SLOW_HALF * 2);
      SSMP_CKS_SLOW4: half_len = `SSMP_DIV_CNT_W'(SLOW_HALF * 4);
      SSMP_CKS_FAST1: half_len = `SSMP_DIV_CNT_W'(FAST_HALF);
      SSMP_CKS_FAST2: half_len = `SSMP_DIV_CNT_W'(FAST_HALF * 2);
      SSMP_CKS_FAST4: half_len = `SSMP_DIV_CNT_W'(FAST_HALF * 4);
      default: half_len = `SSMP_DIV_CNT_W'(1);
    endcase
  endfunction : half_len

  // ==========================================================================
  // divider: restarts whenever the transfer is not running
  always_comb begin
    len = half_len(cks);
    cnt_d = '0;
    tick_d = 1'b0;
    if (run && cks != SSMP_CKS_OFF) begin
      if (cks == SSMP_CKS_TIMER) begin
        tick_d = timer_tick;
      end else if (cnt_q >= len - `SSMP_DIV_CNT_W'(1)) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + `SSMP_DIV_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      half_tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      half_tick <= tick_d;
    end
  end

endmodule : ssmp_clkgen

`default_nettype wire

// ---- ssmp_properties.sv ----
// concurrent checks on pin switching, mode decode and completion of the serial block
`default_nettype none

module ssmp_properties (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic serial_enable_bit, // serial on
  input wire logic master_select_bit, // master
  input wire logic handshake_pin_enable, // bit 3 used
  input wire logic ready_output_select, // ready out
  input wire logic data_out_pin_enable, // bit 1 serial
  input wire logic clk_polarity_neg, // polarity
  input wire logic [3:0] port_dir, // direction
  input wire logic [3:0] port_pulldown, // pull-down
  input wire logic transfer_trigger_bit, // start
  input wire logic busy, // running
  input wire logic transfer_done_flag, // done flag
  input wire logic irq_request, // done pulse
  input wire logic [3:0] port3_out, // pin levels
  input wire logic [3:0] port3_oe, // pin enables
  input wire logic [3:0] port3_pd, // pull-downs
  input wire ssmp_pkg::ssmp_mode_t mode // mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssmp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ========================================================================
  // expected pin terms; the all-ones setting leaves the pins as ports
  wire logic ser_on = serial_enable_bit && !(master_select_bit && handshake_pin_enable
    && ready_output_select);
  wire logic ser_ok = rst_n && ser_on;
  wire logic off_ok = rst_n && !ser_on;
  wire logic [3:0] port_pd = port_pulldown & ~port_dir;
  wire logic pd0_exp = !master_select_bit && port_pulldown[0];
  wire logic oe1_exp = data_out_pin_enable || port_dir[1];
  wire logic oe3_exp = (master_select_bit || !handshake_pin_enable) ? port_dir[3]
    : ready_output_select;
  wire logic mst_idle = ser_ok && master_select_bit && !busy;
  // ========================================================================
  // pin outputs lag the controls by one edge
  port_map_a: assert property ($past(off_ok) |->
    port3_oe == $past(port_dir) && port3_pd == $past(port_pd)) else $error("port map lost");
  clk_dir_a: assert property ($past(ser_ok) |->
    port3_oe[0] == $past(master_select_bit) && !port3_oe[2]) else $error("input dir wrong");
  in_pull_a: assert property ($past(ser_ok) |->
    port3_pd[2] == $past(port_pulldown[2]) && port3_pd[0] == $past(pd0_exp))
    else $error("input pull-down wrong");
  out_en_a: assert property ($past(ser_ok) |-> port3_oe[1] == $past(oe1_exp))
    else $error("data-out enable wrong");
  pin3_dir_a: assert property ($past(ser_ok) |-> port3_oe[3] == $past(oe3_exp))
    else $error("bit 3 direction wrong");
  mode_dec_a: assert property (mode == (!ser_on ? SSMP_MODE_OFF :
    master_select_bit ? SSMP_MODE_MASTER : (handshake_pin_enable && !ready_output_select)
    ? SSMP_MODE_SPI : SSMP_MODE_SLAVE)) else $error("mode decode wrong");
  done_irq_a: assert property (irq_request |-> transfer_done_flag ##1 !irq_request)
    else $error("done pulse wrong");
  // the clock pin may only move once a transfer has started
  clk_idle_a: assert property ($past(mst_idle, 2) && $past(mst_idle) |->
    $stable(port3_out[0])) else $error("idle clock moved");
  ready_up_a: assert property (transfer_trigger_bit && !busy && mode == SSMP_MODE_SLAVE
    && handshake_pin_enable && ready_output_select && !clk_polarity_neg
    |-> ##2 port3_out[3] && port3_oe[3]) else $error("ready not raised");
endmodule : ssmp_properties

bind ssmp_top ssmp_properties chk_i (.clk(clk), .rst_n(rst_n),
  .serial_enable_bit(serial_enable_bit), .master_select_bit(master_select_bit),
  .handshake_pin_enable(handshake_pin_enable), .ready_output_select(ready_output_select),
  .data_out_pin_enable(data_out_pin_enable), .clk_polarity_neg(clk_polarity_neg),
  .port_dir(port_dir), .port_pulldown(port_pulldown), .busy(busy),
  .transfer_trigger_bit(transfer_trigger_bit), .transfer_done_flag(transfer_done_flag),
  .irq_request(irq_request), .port3_out(port3_out), .port3_oe(port3_oe),
  .port3_pd(port3_pd), .mode(mode));

`default_nettype wire

// ---- ssmp_far_end.sv ----
// external serial device: clocks frames as master or follows the block's clock
`default_nettype none

module ssmp_far_end (
  input wire logic dut_sck, // clock pin when the block drives it
  input wire logic dut_sdo, // data-out pin of the block
  output logic sck_o, // our clock, low between frames
  output logic sd_o, // our serial data
  output logic ss_n_o // select, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic own = 1'h0;
  logic [7:0] shf = 8'h00;
  logic [7:0] got = 8'h00;
  wire logic sck = own ? sck_o : dut_sck;
  initial begin
    sck_o = 1'h0;
    sd_o = 1'h0;
    ss_n_o = 1'h1;
  end
  // sample on rise, present the next bit on fall; past the byte the line keeps changing
  always @(posedge sck) got <= {got[6:0], dut_sdo};
  always @(negedge sck) begin
    shf <= {shf[6:0], ~shf[0]};
    sd_o <= shf[6];
  end
  task automatic load(input logic [7:0] b);
    shf = b;
    sd_o = b[7];
  endtask : load
  // one byte at 800 ns per bit; select falls half a period before the first edge
  task automatic frame(input logic [7:0] b, input logic no_sel);
    load(b);
    own = 1'h1;
    ss_n_o = no_sel;
    #400;
    repeat (8) begin
      sck_o = 1'h1;
      #400;
      sck_o = 1'h0;
      #400;
    end
    ss_n_o = 1'h1;
    own = 1'h0;
    sd_o = ~sd_o; // released line shows no stale value
  endtask : frame
endmodule : ssmp_far_end

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the serial mode and pin block with an external partner
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ssmp_pkg::*;
  // ========================================================================
  // stimulus and observed signals
  logic clk = 1'h0, rst_n = 1'h0, ser = 1'h0, msel = 1'h0, hs = 1'h0, rdy = 1'h0;
  logic dout = 1'h0, tick = 1'h0, ton = 1'h0, trig = 1'h0, hi = 1'h0, clr = 1'h0;
  logic busy, done, irq, p_sck, p_sd, p_ss_n;
  logic [3:0] dir = 4'h0, dat = 4'h0, pul = 4'hF, out, oe, pd, piv;
  logic [7:0] txd = 8'h00, rxd;
  ssmp_cks_t cks = SSMP_CKS_OFF;
  ssmp_mode_t mode;
  int fails = 0, samples_checked = 0, tgl = 0;
  // {master, handshake, ready, data-out}, mode, pin enables, pull-downs
  logic [15:0] tbl [5] = '{16'h913C, 16'hC11E, 16'h72A5, 16'h220F, 16'h532D};
  // undriven lines settle at their pull-down or at the partner's level
  wire logic [3:0] pin = {oe[3] ? out[3] : p_ss_n, oe[2] ? out[2] : p_sd,
    oe[1] & out[1], oe[0] ? out[0] : p_sck};
  // master reads data-in through the synchroniser: half periods stay at four clocks or more
  ssmp_top #(.SLOW_HALF(4), .FAST_HALF(4)) dut (.clk(clk), .rst_n(rst_n),
    .serial_enable_bit(ser), .master_select_bit(msel), .handshake_pin_enable(hs),
    .ready_output_select(rdy), .data_out_pin_enable(dout), .clock_source_select(cks),
    .clk_polarity_neg(1'h0), .clk_phase_alt(1'h0), .lsb_first(1'h0), .port_dir(dir),
    .port_data(dat), .port_pulldown(pul), .timer_tick(tick), .tx_data(txd),
    .transfer_trigger_bit(trig), .data_hi_access(hi), .done_clear(clr), .port3_in(pin),
    .port3_out(out), .port3_oe(oe), .port3_pd(pd), .port_in_value(piv), .rx_data(rxd),
    .busy(busy), .transfer_done_flag(done), .irq_request(irq), .mode(mode));
  ssmp_far_end far (.dut_sck(out[0] & oe[0]), .dut_sdo(out[1] & oe[1]), .sck_o(p_sck),
    .sd_o(p_sd), .ss_n_o(p_ss_n));
  // 10 MHz clock; each clock pin change is one half period
  always #50 clk = ~clk;
  always @(out[0]) tgl++;
  // timer underflow every fourth cycle while enabled
  always begin
    step(3);
    tick = ton;
    step(1);
    tick = 1'h0;
  end
  // ========================================================================
  // helpers: inputs always move 5 ns after an edge so no race with the block
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_for(input logic want_done, input int lim);
    int n;
    n = 0;
    while ((want_done ? done !== 1'h1 : busy !== 1'h0) && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      fails++;
      $display("Error at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask : wait_for
  task automatic pulse_trig();
    trig = 1'h1;
    step(1);
    trig = 1'h0;
  endtask : pulse_trig
  task automatic clear_done();
    clr = 1'h1;
    step(1);
    clr = 1'h0;
  endtask : clear_done
  // ========================================================================
  // scenarios
  // plain ports after reset and under the prohibited all-ones setting
  task automatic t_ports();
    dir = 4'h5;
    dat = 4'hC;
    step(2);
    chk({oe, pd}, 8'h5A);
    chk(8'(out & oe), 8'h04);
    {ser, msel, hs, rdy} = 4'hF;
    step(2);
    chk({oe, pd}, 8'h5A);
    chk(8'(piv), 8'h0C);
    $display("ports test done");
  endtask : t_ports
  // master, slave and SPI settings; direction bits set where serial inputs must ignore them
  task automatic t_modes();
    for (int i = 0; i < 5; i++) begin
      {msel, hs, rdy, dout} = tbl[i][15:12];
      step(2);
      chk(8'(mode), {4'h0, tbl[i][11:8]});
      chk({oe, pd}, tbl[i][7:0]);
    end
    $display("modes test done");
  endtask : t_modes
  // all seven master sources, the timer among them
  task automatic t_master();
    {ser, msel, hs, rdy, dout} = 5'h19;
    ton = 1'h1;
    for (int k = 1; k < 8; k++) begin
      cks = ssmp_cks_t'(k);
      far.load(8'h30 + 8'(k));
      txd = 8'hC5;
      step(2);
      tgl = 0;
      pulse_trig();
      wait_for(1'h1, 400);
      chk(8'(irq), 8'h01);
      chk(rxd, 8'h30 + 8'(k));
      wait_for(1'h0, 60);
      step(2);
      chk(8'(tgl), 8'h10);
      clear_done();
      chk(8'(done), 8'h00);
    end
    ton = 1'h0;
    $display("master test done");
  endtask : t_master
  // slave: hardware ready, byte both ways, ready dropped by the upper-data access
  task automatic t_slave();
    {msel, hs, rdy, dout} = 4'h7;
    cks = SSMP_CKS_OFF;
    txd = 8'h96;
    step(2);
    pulse_trig();
    step(2);
    chk(8'(out[3]), 8'h01);
    far.frame(8'h5B, 1'h0);
    wait_for(1'h1, 20);
    chk(rxd, 8'h5B);
    chk(far.got, 8'h96);
    chk(8'(out[3]), 8'h00);
    clear_done();
    pulse_trig();
    step(2);
    chk(8'(out[3]), 8'h01);
    hi = 1'h1;
    step(1);
    hi = 1'h0;
    step(2);
    chk(8'(out[3]), 8'h00);
    ser = 1'h0;
    step(2);
    $display("slave test done");
  endtask : t_slave
  // select gates the clock: an unselected frame leaves the transfer waiting
  task automatic t_spi();
    {ser, msel, hs, rdy, dout} = 5'h15;
    txd = 8'h3A;
    step(2);
    pulse_trig();
    far.frame(8'hE1, 1'h1);
    step(4);
    chk(8'(done), 8'h00);
    far.frame(8'hE1, 1'h0);
    wait_for(1'h1, 20);
    chk(rxd, 8'hE1);
    chk(far.got, 8'h3A);
    $display("spi test done");
  endtask : t_spi
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // reset for two cycles, then the scenarios in turn
  initial begin
    step(2);
    rst_n = 1'h1;
    t_ports();
    t_modes();
    t_master();
    t_slave();
    t_spi();
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
